// [ccs_map.vh]
`ifndef CCS_MAP_VH
`define CCS_MAP_VH
// Register offsets
`define CCS_REG_CTRL 4'h0
`define CCS_REG_LEN_FIRST 4'h1
`define CCS_REG_LEN_SECOND 4'h2
`define CCS_REG_SW_CFG 4'h3
`define CCS_REG_STATUS 4'h4
`define CCS_REG_MAP_FIRST 4'h5
`define CCS_REG_MAP_SECOND 4'h6
`define CCS_REG_SWITCHES 4'h7
// Control fields
`define CCS_CTRL_VER2 0
`define CCS_CTRL_RESTART 1
`define CCS_CTRL_LINK 2
`define CCS_CTRL_TIMEOUT 3
`define CCS_CTRL_CRCERR 4
`define CCS_CTRL_EXT_LO 8
`define CCS_CTRL_EXT_HI 9
`define CCS_CTRL_OCC_LO 12
`define CCS_CTRL_OCC_HI 13
// Switch and setting values
`define CCS_SW_SOFT 4'h9
`define CCS_DEC_TEN 7'h0A
`define CCS_STN_MIN 7'h01
`define CCS_STN_MAX 7'h40
`define CCS_BAUD_MAX 4'h4
`define CCS_STN_SOFT 7'h63
`define CCS_CTRL_MASK 16'h331D
`define CCS_SWC_MASK 16'h077F
`define CCS_SWC_RST 16'h0001
`define CCS_SWC_STN_HI 6
`define CCS_SWC_BAUD_LO 8
`define CCS_SWC_BAUD_HI 10
// Data length limits
`define CCS_LEN_CAP 9'h0C8
`define CCS_V1_STEP1 9'h004
`define CCS_V1_STEP2 9'h00C
`define CCS_V1_STEP3 9'h018
`define CCS_V1_STEP4 9'h024
`define CCS_V1_STEP5 9'h030
`define CCS_V1_BIT1 8'h04
`define CCS_V1_BITSTEP 8'h04
`define CCS_V1_WORD_MAX 8'h20
`define CCS_SETTLE_CYC 4'h3
`endif

// [ccs_len_map.v]
`timescale 1ns/10ps
`include "ccs_map.vh"
module ccs_len_map (
	input wire ver2,
	input wire [1:0] ext_sel,
	input wire [1:0] occ_sel,
	input wire [8:0] len,
	output reg [2:0] stations,
	output reg [7:0] bit_bytes,
	output reg [7:0] word_bytes,
	output reg len_err
);
	reg [8:0] capped;
	reg [8:0] v2_tot;
	// ************************************
	// Version 2 total lengths
	// ************************************
	function [8:0] v2_len;
		input [1:0] e;
		input [1:0] o;
		begin
			case ({e, o})
				4'h0: v2_len = 9'h00C;
				4'h1: v2_len = 9'h018;
				4'h2: v2_len = 9'h024;
				4'h3: v2_len = 9'h030;
				4'h4: v2_len = 9'h014;
				4'h5: v2_len = 9'h02C;
				4'h6: v2_len = 9'h044;
				4'h7: v2_len = 9'h05C;
				4'h8: v2_len = 9'h028;
				4'h9: v2_len = 9'h058;
				4'hA: v2_len = 9'h088;
				4'hB: v2_len = 9'h0B8;
				4'hC: v2_len = 9'h050;
				4'hD: v2_len = 9'h0B0;
				4'hE: v2_len = 9'h110;
				default: v2_len = 9'h170;
			endcase
		end
	endfunction
	// Bit bytes per station and cycle
	function [7:0] v2_bits;
		input [1:0] e;
		input [1:0] o;
		begin
			case ({e, o})
				4'h0: v2_bits = 8'h04;
				4'h1: v2_bits = 8'h08;
				4'h2: v2_bits = 8'h0C;
				4'h3: v2_bits = 8'h10;
				4'h4: v2_bits = 8'h04;
				4'h5: v2_bits = 8'h0C;
				4'h6: v2_bits = 8'h14;
				4'h7: v2_bits = 8'h1C;
				4'h8: v2_bits = 8'h08;
				4'h9: v2_bits = 8'h18;
				4'hA: v2_bits = 8'h28;
				4'hB: v2_bits = 8'h38;
				4'hC: v2_bits = 8'h10;
				4'hD: v2_bits = 8'h30;
				4'hE: v2_bits = 8'h50;
				default: v2_bits = 8'h70;
			endcase
		end
	endfunction
	always @* begin
		capped = (len > `CCS_LEN_CAP) ? `CCS_LEN_CAP : len;
		v2_tot = v2_len(ext_sel, occ_sel);
		stations = 3'h1;
		bit_bytes = 8'h00;
		word_bytes = 8'h00;
		len_err = 1'b0;
		if (ver2) begin
			stations = {1'b0, occ_sel} + 3'h1;
			bit_bytes = v2_bits(ext_sel, occ_sel);
			word_bytes = v2_tot[7:0] - bit_bytes;
			if (v2_tot[8])
				word_bytes = 8'h00;
			len_err = (capped != v2_tot);
		end else begin
			if (capped <= `CCS_V1_STEP1) begin
				stations = 3'h1;
				bit_bytes = capped[7:0];
			end else if (capped <= `CCS_V1_STEP2) begin
				stations = 3'h1;
				bit_bytes = `CCS_V1_BIT1;
			end else if (capped <= `CCS_V1_STEP3) begin
				stations = 3'h2;
				bit_bytes = `CCS_V1_BIT1 + `CCS_V1_BITSTEP;
			end else if (capped <= `CCS_V1_STEP4) begin
				stations = 3'h3;
				bit_bytes = `CCS_V1_BIT1 + `CCS_V1_BITSTEP + `CCS_V1_BITSTEP;
			end else begin
				stations = 3'h4;
				bit_bytes = `CCS_V1_BIT1 + `CCS_V1_BITSTEP + `CCS_V1_BITSTEP + `CCS_V1_BITSTEP;
			end
			if (capped > `CCS_V1_STEP1)
				word_bytes = capped[7:0] - bit_bytes;
			if (capped > `CCS_V1_STEP5)
				word_bytes = `CCS_V1_WORD_MAX;
		end
	end
endmodule

// [ccs_station_cfg.v]
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "ccs_map.vh"
// Operation
// - Station number is tens switch times ten plus ones switch, 1 to 64.
// - Switches reading 99 take station number from software setting.
// - Station number is sampled after power-up and again after each restart.
// - Baud switch 0..4 picks 156k..10M; 9 picks software rate.
// - Software station needs both station switches at nine; software baud needs only the baud switch at nine.
// - New station or baud settings apply only after restart.
// - Device occupies one to four station areas.
// - Version 1 carries at most 48 bytes: 16 bit, 32 word.
// - Configured data length is capped at 200 bytes.
// - Version 1 derives stations, bit and word bytes from length.
// - Version 1 data past byte 48 is not exchanged.
// - Version 2 uses 1, 2, 4 or 8 cycles with 1-4 stations.
// - Version 2 sizes bits, words, total from stations and cycles.
// - Version 2 length not in table raises error.
// - Process data uses both bit and word areas.
// - Run indicator on only in run state with link up and no timeout, else off.
// - Error indicator on for CRC, bad station or bad baud.
module ccs_station_cfg (
	input wire mclk,
	input wire sys_rst,
	input wire [3:0] station_tens_switch,
	input wire [3:0] station_ones_switch,
	input wire [3:0] baud_select_switch,
	input wire rx_active,
	input wire tx_active,
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	output reg [6:0] station_num,
	output reg [2:0] baud_code,
	output reg [2:0] occupied_stations,
	output reg [7:0] bit_bytes_first,
	output reg [7:0] word_bytes_first,
	output reg [7:0] bit_bytes_second,
	output reg [7:0] word_bytes_second,
	output reg run_indicator,
	output reg error_indicator,
	output reg receive_indicator,
	output reg send_indicator
);
	localparam ST_SYNC = 3'b001;
	localparam ST_LOAD = 3'b010;
	localparam ST_RUN = 3'b100;
	reg [2:0] state_q;
	reg [11:0] sw_s1_q, sw_s2_q, sw_s3_q;
	reg [1:0] act_s1_q, act_s2_q, act_s3_q;
	reg [3:0] settle_q;
	reg [15:0] ctrl_q;
	reg [8:0] len_first_q, len_second_q;
	reg [15:0] sw_cfg_q;
	reg [1:0] ext_run_q, occ_run_q;
	reg ver2_run_q;
	reg [6:0] sw_station;
	reg stn_bad, baud_bad, soft_sel;
	reg cfg_bad_q;
	reg [6:0] station_d;
	reg [2:0] baud_d;
	reg stn_bad_d;
	reg baud_bad_d;
	wire [2:0] st_a, st_b;
	wire [7:0] bb_a, wb_a, bb_b, wb_b;
	wire err_a, err_b;
	wire [3:0] tens_sync;
	wire [3:0] ones_sync;
	wire [3:0] baud_sync;
	wire [6:0] soft_station;
	wire [2:0] soft_baud;
	wire restart_req;
	// ************************************
	// Setting checks
	// ************************************
	// Station range
	function stn_invalid;
		input [6:0] s;
		begin
			stn_invalid = (s < `CCS_STN_MIN) || (s > `CCS_STN_MAX);
		end
	endfunction
	function baud_invalid;
		input [3:0] b;
		begin
			baud_invalid = (b > `CCS_BAUD_MAX);
		end
	endfunction
	// ************************************
	// Pin synchronisers
	// ************************************
	always @(posedge mclk) begin
		sw_s1_q <= {station_tens_switch, station_ones_switch, baud_select_switch};
		sw_s2_q <= sw_s1_q;
		sw_s3_q <= sw_s2_q;
		act_s1_q <= {rx_active, tx_active};
		act_s2_q <= act_s1_q;
		act_s3_q <= act_s2_q;
	end
	// ************************************
	// Synchronised fields
	// ************************************
	assign tens_sync = sw_s3_q[11:8];
	assign ones_sync = sw_s3_q[7:4];
	assign baud_sync = sw_s3_q[3:0];
	assign soft_station = sw_cfg_q[`CCS_SWC_STN_HI:0];
	assign soft_baud = sw_cfg_q[`CCS_SWC_BAUD_HI:`CCS_SWC_BAUD_LO];
	assign restart_req = reg_wr && (reg_addr == `CCS_REG_CTRL) &&
		reg_wdata[`CCS_CTRL_RESTART];
	// ************************************
	// Switch decode
	// ************************************
	always @* begin
		sw_station = {3'h0, tens_sync} * `CCS_DEC_TEN + {3'h0, ones_sync};
		soft_sel = (tens_sync == `CCS_SW_SOFT) && (ones_sync == `CCS_SW_SOFT) &&
			(baud_sync == `CCS_SW_SOFT);
		if (sw_station == `CCS_STN_SOFT)
			station_d = soft_station;
		else
			station_d = sw_station;
		if (soft_sel || baud_sync == `CCS_SW_SOFT)
			baud_d = soft_baud;
		else
			baud_d = baud_sync[2:0];
		stn_bad_d = stn_invalid(station_d);
		if (baud_sync == `CCS_SW_SOFT)
			baud_bad_d = baud_invalid({1'b0, soft_baud});
		else
			baud_bad_d = baud_invalid(baud_sync);
	end
	// ************************************
	// Start-up sampling
	// ************************************
	always @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= ST_SYNC;
			settle_q <= 4'h0;
			station_num <= 7'h00;
			baud_code <= 3'h0;
			ver2_run_q <= 1'b0;
			ext_run_q <= 2'h0;
			occ_run_q <= 2'h0;
			stn_bad <= 1'b0;
			baud_bad <= 1'b0;
		end else begin
			case (state_q)
				ST_SYNC: begin
					settle_q <= settle_q + 4'h1;
					if (settle_q == `CCS_SETTLE_CYC && sw_s2_q == sw_s3_q)
						state_q <= ST_LOAD;
				end
				ST_LOAD: begin
					state_q <= ST_RUN;
					ver2_run_q <= ctrl_q[`CCS_CTRL_VER2];
					ext_run_q <= ctrl_q[`CCS_CTRL_EXT_HI:`CCS_CTRL_EXT_LO];
					occ_run_q <= ctrl_q[`CCS_CTRL_OCC_HI:`CCS_CTRL_OCC_LO];
					station_num <= station_d;
					baud_code <= baud_d;
					stn_bad <= stn_bad_d;
					baud_bad <= baud_bad_d;
				end
				ST_RUN: begin
					if (restart_req) begin
						state_q <= ST_SYNC;
						settle_q <= 4'h0;
					end
				end
				default: state_q <= ST_SYNC;
			endcase
		end
	end
	// ************************************
	// Software registers
	// ************************************
	always @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_q <= 16'h0000;
			len_first_q <= 9'h000;
			len_second_q <= 9'h000;
			sw_cfg_q <= `CCS_SWC_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`CCS_REG_CTRL: ctrl_q <= reg_wdata & `CCS_CTRL_MASK;
				`CCS_REG_LEN_FIRST: len_first_q <= reg_wdata[8:0];
				`CCS_REG_LEN_SECOND: len_second_q <= reg_wdata[8:0];
				`CCS_REG_SW_CFG: sw_cfg_q <= reg_wdata & `CCS_SWC_MASK;
				default: ;
			endcase
		end
	end
	// ************************************
	// Data length mapping
	// ************************************
	ccs_len_map u_map_first (
		.ver2(ver2_run_q),
		.ext_sel(ext_run_q),
		.occ_sel(occ_run_q),
		.len(len_first_q),
		.stations(st_a),
		.bit_bytes(bb_a),
		.word_bytes(wb_a),
		.len_err(err_a)
	);
	ccs_len_map u_map_second (
		.ver2(ver2_run_q),
		.ext_sel(ext_run_q),
		.occ_sel(occ_run_q),
		.len(len_second_q),
		.stations(st_b),
		.bit_bytes(bb_b),
		.word_bytes(wb_b),
		.len_err(err_b)
	);
	always @(posedge mclk) begin
		if (sys_rst) begin
			occupied_stations <= 3'h1;
			bit_bytes_first <= 8'h00;
			word_bytes_first <= 8'h00;
			bit_bytes_second <= 8'h00;
			word_bytes_second <= 8'h00;
			cfg_bad_q <= 1'b0;
		end else begin
			occupied_stations <= (st_a > st_b) ? st_a : st_b;
			bit_bytes_first <= bb_a;
			word_bytes_first <= wb_a;
			bit_bytes_second <= bb_b;
			word_bytes_second <= wb_b;
			cfg_bad_q <= err_a | err_b;
		end
	end
	// ************************************
	// Indicators
	// ************************************
	always @(posedge mclk) begin
		if (sys_rst) begin
			run_indicator <= 1'b0;
			error_indicator <= 1'b0;
		end else begin
			run_indicator <= (state_q == ST_RUN) && ctrl_q[`CCS_CTRL_LINK] &&
				!ctrl_q[`CCS_CTRL_TIMEOUT];
			error_indicator <= (state_q == ST_RUN) && (ctrl_q[`CCS_CTRL_CRCERR] ||
				stn_bad || baud_bad || cfg_bad_q);
		end
	end
	// ************************************
	// Activity indicators
	// ************************************
	always @(posedge mclk) begin
		if (sys_rst) begin
			receive_indicator <= 1'b0;
			send_indicator <= 1'b0;
		end else begin
			// Follow once stages agree
			if (act_s2_q[1] == act_s3_q[1])
				receive_indicator <= act_s3_q[1];
			if (act_s2_q[0] == act_s3_q[0])
				send_indicator <= act_s3_q[0];
		end
	end
	// ************************************
	// Register read
	// ************************************
	always @(posedge mclk) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`CCS_REG_CTRL: reg_rdata <= ctrl_q;
				`CCS_REG_LEN_FIRST: reg_rdata <= {7'h00, len_first_q};
				`CCS_REG_LEN_SECOND: reg_rdata <= {7'h00, len_second_q};
				`CCS_REG_SW_CFG: reg_rdata <= sw_cfg_q;
				`CCS_REG_STATUS: reg_rdata <= {state_q, cfg_bad_q, baud_bad, stn_bad,
					occupied_stations, baud_code, station_num[3:0]} & 16'hFFFF;
				`CCS_REG_MAP_FIRST: reg_rdata <= {word_bytes_first, bit_bytes_first};
				`CCS_REG_MAP_SECOND: reg_rdata <= {word_bytes_second, bit_bytes_second};
				`CCS_REG_SWITCHES: reg_rdata <= {1'b0, station_num, 4'h0, sw_s3_q[3:0]};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule

// [ccs_station_cfg_assertions.sv]
`timescale 1ns/10ps
`include "ccs_map.vh"
module ccs_cfg_chk (
	input wire mclk,
	input wire sys_rst,
	input wire rx_active,
	input wire tx_active,
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	input wire [6:0] station_num,
	input wire [2:0] baud_code,
	input wire [2:0] occupied_stations,
	input wire [7:0] bit_bytes_first,
	input wire [7:0] word_bytes_first,
	input wire [7:0] bit_bytes_second,
	input wire [7:0] word_bytes_second,
	input wire error_indicator,
	input wire receive_indicator,
	input wire send_indicator
);
// ****
// Checks
// ****
logic [4:0] cnt_q = 5'h00;
always @(posedge mclk) begin
	if (sys_rst || (reg_wr && reg_addr == `CCS_REG_CTRL && reg_wdata[`CCS_CTRL_RESTART]))
		cnt_q <= 5'h00;
	else if (cnt_q != 5'h1F)
		cnt_q <= cnt_q + 5'h01;
end
default clocking @(posedge mclk); endclocking
default disable iff (sys_rst);
sequence unmapped_rd;
	reg_rd && reg_addr > `CCS_REG_SWITCHES;
endsequence
sequence rx_steady;
	$stable(rx_active) [*8];
endsequence
rd_unmapped_a: assert property (unmapped_rd |=> reg_rdata == 16'h0000)
	else $error("unmapped read returned data");
rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
	else $error("read data outside read slot");
occ_range_a: assert property (occupied_stations >= 3'h1 && occupied_stations <= 3'h4)
	else $error("occupied stations out of range");
baud_range_a: assert property (cnt_q >= 5'h0C && baud_code > 3'h4 |-> error_indicator)
	else $error("invalid baud code without error indication");
len_cap_a: assert property (({1'b0, bit_bytes_first} + {1'b0, word_bytes_first} <= `CCS_LEN_CAP)
	&& ({1'b0, bit_bytes_second} + {1'b0, word_bytes_second} <= `CCS_LEN_CAP))
	else $error("mapped length above cap");
no_word_a: assert property (bit_bytes_first == 8'h00 |-> word_bytes_first == 8'h00)
	else $error("word data without bit data");
cfg_hold_a: assert property (cnt_q == 5'h1F |-> $stable(station_num) && $stable(baud_code))
	else $error("station or baud changed without restart");
rx_follow_a: assert property (rx_steady |-> receive_indicator == rx_active)
	else $error("receive indicator does not follow link");
tx_follow_a: assert property ($stable(tx_active) [*8] |-> send_indicator == tx_active)
	else $error("send indicator does not follow link");
endmodule
bind ccs_station_cfg ccs_cfg_chk u_chk (.*);

// [ccs_master_model.sv]
`timescale 1ns/10ps
module ccs_master_model (
	input wire mclk,
	input wire poll,
	output logic rx_active = 1'b0,
	output logic tx_active = 1'b0
);
// ****
// Master polling
// ****
logic [4:0] ph_q = 5'h00;
always @(posedge mclk) begin
	if (!poll) begin
		ph_q <= 5'h00;
		rx_active <= 1'b0;
		tx_active <= 1'b0;
	end else begin
		ph_q <= ph_q + 5'h01;
		rx_active <= ph_q < 5'h0C;
		tx_active <= ph_q >= 5'h10 && ph_q < 5'h1C;
	end
end
endmodule

// [tb.sv]
`timescale 1ns/10ps
`include "ccs_map.vh"
module tb;
logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, poll = 1'b0;
logic [3:0] station_tens_switch = 4'h6, station_ones_switch = 4'h4, baud_select_switch = 4'h4;
logic [3:0] reg_addr = 4'h0;
logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
logic rx_active, tx_active, run_indicator, error_indicator, receive_indicator, send_indicator;
logic [6:0] station_num;
logic [2:0] baud_code, occupied_stations;
logic [7:0] bit_bytes_first, word_bytes_first, bit_bytes_second, word_bytes_second;
logic [23:0] ea, eb;
integer fails = 0, cmp_count = 0, i, j, a, b, e, bt, wd;
integer tbl[13] = '{0, 4, 5, 12, 13, 24, 25, 36, 37, 48, 49, 200, 511};
always #2.5 mclk = ~mclk;
ccs_master_model u_mst (.*);
ccs_station_cfg dut (.*);
// ****
// Helpers
// ****
task chk(input logic [31:0] got, input logic [31:0] exp);
	cmp_count++;
	if (got !== exp) begin
		fails++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask
task wr(input logic [3:0] a, input logic [15:0] v);
	@(posedge mclk);
	reg_addr <= a;
	reg_wdata <= v;
	reg_wr <= 1'b1;
	@(posedge mclk);
	reg_wr <= 1'b0;
endtask
task rd(input logic [3:0] a, output logic [15:0] q);
	@(posedge mclk);
	reg_addr <= a;
	reg_rd <= 1'b1;
	@(posedge mclk);
	reg_rd <= 1'b0;
	#1 q = reg_rdata;
endtask
task sw(input integer t, input integer o, input integer s);
	@(posedge mclk);
	station_tens_switch <= 4'(t);
	station_ones_switch <= 4'(o);
	baud_select_switch <= 4'(s);
endtask
task rs(input integer c);
	wr(`CCS_REG_CTRL, 16'(c) | 16'h0002);
	repeat (12) @(posedge mclk);
endtask
function automatic [23:0] v1m(input integer l);
	integer m, st, bb;
	begin
		m = (l > 48) ? 48 : l;
		st = (m <= 12) ? 1 : (m - 1) / 12 + 1;
		bb = (m <= 4) ? m : 4 * st;
		v1m = {8'(st), 8'(bb), 8'(m - bb)};
	end
endfunction
task test_done;
	$display("Comparisons %0d mismatches %0d", cmp_count, fails);
	if (fails == 0 && cmp_count > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
initial begin
	#150000;
	fails++;
	test_done;
end
// ****
// Tests
// ****
initial begin
	void'($urandom(12));
	repeat (15) @(posedge mclk);
	#1 chk(32'(occupied_stations), 1);
	@(posedge mclk);
	sys_rst <= 1'b0;
	repeat (12) @(posedge mclk);
	e = 64;
	chk(32'(station_num), e);
	for (i = 0; i < 5; i++) begin
		sw(i, i + 1, i);
		repeat (12) @(posedge mclk);
		chk(32'(station_num), e);
		rs(0);
		e = 11 * i + 1;
		chk(32'(station_num), e);
		chk(32'(baud_code), i);
	end
	wr(`CCS_REG_SW_CFG, 16'h0321);
	sw(9, 9, 9);
	rs(0);
	chk(32'(station_num), 33);
	chk(32'(baud_code), 3);
	rd(`CCS_REG_SWITCHES, d);
	chk(32'(d), 32'h00002109);
	sw(7, 0, 6);
	rs(4);
	rd(`CCS_REG_STATUS, d);
	chk(32'(d[11:10]), 3);
	chk(32'(error_indicator), 1);
	sw(1, 0, 0);
	rs(4);
	chk(32'(error_indicator), 0);
	chk(32'(run_indicator), 1);
	wr(`CCS_REG_CTRL, 16'h0014);
	repeat (8) @(posedge mclk);
	chk(32'(error_indicator), 1);
	wr(`CCS_REG_CTRL, 16'h000C);
	repeat (8) @(posedge mclk);
	chk(32'(run_indicator), 0);
	rd(4'hF, d);
	chk(32'(d), 0);
	poll <= 1'b1;
	for (i = 0; i < 33; i++) begin
		a = (i < 13) ? tbl[i] : $urandom % 512;
		b = $urandom % 512;
		wr(`CCS_REG_LEN_FIRST, 16'(a));
		wr(`CCS_REG_LEN_SECOND, 16'(b));
		repeat (4) @(posedge mclk);
		ea = v1m(a);
		eb = v1m(b);
		chk(32'(bit_bytes_first), 32'(ea[15:8]));
		chk(32'(word_bytes_first), 32'(ea[7:0]));
		chk(32'(bit_bytes_second), 32'(eb[15:8]));
		chk(32'(word_bytes_second), 32'(eb[7:0]));
		chk(32'(occupied_stations), 32'((ea[23:16] > eb[23:16]) ? ea[23:16] : eb[23:16]));
		rd(`CCS_REG_MAP_FIRST, d);
		chk(32'(d), 32'({ea[7:0], ea[15:8]}));
		rd(`CCS_REG_MAP_SECOND, d);
		chk(32'(d), 32'({eb[7:0], eb[15:8]}));
	end
	poll <= 1'b0;
	repeat (8) @(posedge mclk);
	chk(32'({receive_indicator, send_indicator}), 0);
	for (i = 1; i <= 4; i++) begin
		for (j = 0; j < 4; j++) begin
			bt = (j > 0) ? (4 << j) * i - (2 << j) : 4 * i;
			wd = (8 << j) * i;
			if (bt + wd <= 200) begin
				rs(((i - 1) << 12) | (j << 8) | 1);
				wr(`CCS_REG_LEN_FIRST, 16'(bt + wd));
				wr(`CCS_REG_LEN_SECOND, 16'(bt + wd));
				repeat (4) @(posedge mclk);
				chk(32'(bit_bytes_first), bt);
				chk(32'(word_bytes_first), wd);
				chk(32'(bit_bytes_second), bt);
				chk(32'(word_bytes_second), wd);
				chk(32'(occupied_stations), i);
				rd(`CCS_REG_STATUS, d);
				chk(32'(d[12]), 0);
				chk(32'(error_indicator), 0);
				wr(`CCS_REG_LEN_SECOND, 16'(bt + wd + 1));
				repeat (4) @(posedge mclk);
				rd(`CCS_REG_STATUS, d);
				chk(32'(d[12]), 1);
				chk(32'(error_indicator), 1);
			end
		end
	end
	test_done;
end
endmodule
